/* core/dot_panel_pkg.sv */
// constants, field positions and carriers for the dot-matrix panel front end
package dot_panel_pkg;

  localparam int DATA_W = 8;
  localparam int ROWS = 16;
  localparam int COL_BYTES = 5;
  localparam int DOTS = 40;

  localparam logic [7:0] REG_RESET = 8'h00;

  // low three bits of the pointer name the indexed register
  localparam int PTR_SEL_MSB = 2;
  localparam int PTR_SEL_LSB = 0;
  localparam logic [2:0] SEL_SETUP = 3'h0;
  localparam logic [2:0] SEL_CONTROL = 3'h1;
  localparam logic [2:0] SEL_POSITION = 3'h2;
  localparam logic [2:0] SEL_FRAME = 3'h3;
  localparam logic [2:0] SEL_DATA = 3'h4;

  // panel_setup fields
  localparam int SETUP_SLEEP_BIT = 5;
  localparam int SETUP_DUTY_BIT = 1;

  // panel_control fields
  localparam int CTRL_ON_BIT = 6;
  localparam int CTRL_SUPPLY_BIT = 5;
  localparam int CTRL_DIVIDER_BIT = 4;
  localparam int CTRL_HOLD_BIT = 3;
  localparam int CTRL_AXIS_BIT = 1;

  // ram_position fields
  localparam int POS_COL_MSB = 7;
  localparam int POS_COL_LSB = 5;
  localparam int POS_ROW_MSB = 3;
  localparam int POS_ROW_LSB = 0;

  localparam logic [2:0] COL_MAX = 3'h4;
  localparam logic [3:0] ROW_MAX_FULL = 4'hf;
  localparam logic [3:0] ROW_MAX_EIGHTH = 4'h7;
  localparam logic [15:0] BACKPLANE_FIRST = 16'h0001;

  typedef struct packed {
    logic register_space_select;
    logic read_not_write;
    logic access_pulse;
    logic [DATA_W-1:0] data;
  } host_port_s;

  typedef struct packed {
    logic [ROWS-1:0] backplane_drive_outputs;
    logic [DOTS-1:0] column_drive_outputs;
  } panel_drive_s;

  typedef struct packed {
    logic module_sleep;
    logic supply_to_ladder_on;
    logic ladder_divider_on;
  } supply_ctrl_s;

endpackage

/* core/sync_stage.sv */
// three-flop synchroniser with agreement filter
`timescale 1ns/1ns
module sync_stage #(
  parameter int W = 1
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] agreed;
  } state_s;

  state_s r;
  state_s r_nxt;

  always_comb begin
    r_nxt = r;
    r_nxt.s1 = async_i;
    r_nxt.s2 = r.s1;
    r_nxt.s3 = r.s2;
    // a bit moves only when the second and third stages agree
    r_nxt.agreed = (r.s2 & r.s3) | (r.agreed & (r.s2 | r.s3));
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign sync_o = r.agreed;

endmodule

/* core/dot_matrix_panel_control_regs.sv */
// register front end, bitmap memory and scan of the dot-matrix panel
`timescale 1ns/1ns
module dot_matrix_panel_control_regs (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire dot_panel_pkg::host_port_s host_port_i,
  output logic [dot_panel_pkg::DATA_W-1:0] rdata_o,
  output logic rdata_oe_o,
  output dot_panel_pkg::panel_drive_s panel_drive_o,
  output dot_panel_pkg::supply_ctrl_s supply_o
);
  import dot_panel_pkg::*;

  typedef struct packed {
    logic strobe_prev;
    logic [7:0] index_pointer;
    logic [7:0] panel_setup;
    logic [7:0] panel_control;
    logic [2:0] column_position;
    logic [3:0] row_position;
    logic [DATA_W-1:0] read_latch;
    logic [3:0] scan_row;
    panel_drive_s drive;
    logic [ROWS-1:0][COL_BYTES-1:0][DATA_W-1:0] ram_bits;
  } state_s;

  state_s r;
  state_s r_nxt;
  host_port_s port;
  logic fall;
  logic [2:0] sel;
  logic duty_eighth_select;
  logic readback_hold_mode;
  logic axis_column_first;
  logic panel_output_on;
  logic [3:0] row_max;
  logic data_access;
  logic data_write;
  logic data_read;
  logic step;
  logic col_ok;

  // selects, direction and data share one synchroniser
  sync_stage #(
    .W($bits(host_port_s))
  ) u_port_sync (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .async_i(host_port_i),
    .sync_o(port)
  );

  assign fall = r.strobe_prev & ~port.access_pulse;
  assign sel = r.index_pointer[PTR_SEL_MSB:PTR_SEL_LSB];
  assign duty_eighth_select = r.panel_setup[SETUP_DUTY_BIT];
  assign readback_hold_mode = r.panel_control[CTRL_HOLD_BIT];
  assign axis_column_first = r.panel_control[CTRL_AXIS_BIT];
  assign panel_output_on = r.panel_control[CTRL_ON_BIT]
                           & ~r.panel_setup[SETUP_SLEEP_BIT];
  assign row_max = duty_eighth_select ? ROW_MAX_EIGHTH
                                      : ROW_MAX_FULL;
  assign data_access = fall & port.register_space_select
                       & (sel == SEL_DATA);
  assign data_write = data_access & ~port.read_not_write;
  assign data_read = data_access & port.read_not_write;
  assign step = data_write
                | (data_read & ~readback_hold_mode);
  // columns five to seven have no storage behind them
  assign col_ok = r.column_position <= COL_MAX;

  always_comb begin
    r_nxt = r;
    r_nxt.strobe_prev = port.access_pulse;
    if (fall && !port.register_space_select) begin
      if (!port.read_not_write) begin
        r_nxt.index_pointer = port.data;
      end
    end else if (fall && !port.read_not_write) begin
      case (sel)
        SEL_SETUP: begin
          r_nxt.panel_setup = port.data;
          if (port.data[SETUP_SLEEP_BIT]) begin
            r_nxt.panel_control[CTRL_ON_BIT] = 1'b0;
            r_nxt.panel_control[CTRL_SUPPLY_BIT] = 1'b0;
            r_nxt.panel_control[CTRL_DIVIDER_BIT] = 1'b0;
          end
        end
        SEL_CONTROL: begin
          r_nxt.panel_control = port.data;
        end
        SEL_POSITION: begin
          r_nxt.column_position = port.data[POS_COL_MSB:POS_COL_LSB];
          r_nxt.row_position = port.data[POS_ROW_MSB:POS_ROW_LSB];
        end
        SEL_DATA: begin
          if (col_ok) begin
            r_nxt.ram_bits[r.row_position][r.column_position] =
              port.data;
          end
        end
        // frame-rate code is accepted but has no effect here
        SEL_FRAME: begin
          r_nxt.index_pointer = r.index_pointer;
        end
        default: begin
          r_nxt.index_pointer = r.index_pointer;
        end
      endcase
    end
    if (data_read) begin
      r_nxt.read_latch = col_ok
        ? r.ram_bits[r.row_position][r.column_position]
        : '0;
    end
    if (step) begin
      if (!axis_column_first) begin
        if (r.row_position >= row_max) begin
          r_nxt.row_position = '0;
          r_nxt.column_position = (r.column_position >= COL_MAX)
            ? '0 : 3'(r.column_position + 3'h1);
        end else begin
          r_nxt.row_position = 4'(r.row_position + 4'h1);
        end
      end else begin
        if (r.column_position >= COL_MAX) begin
          r_nxt.column_position = '0;
          r_nxt.row_position = (r.row_position >= row_max)
            ? '0 : 4'(r.row_position + 4'h1);
        end else begin
          r_nxt.column_position = 3'(r.column_position + 3'h1);
        end
      end
    end
    // scan walks only the rows of the chosen duty
    r_nxt.scan_row = (r.scan_row >= row_max)
      ? '0 : 4'(r.scan_row + 4'h1);
    // a row left over from sixteen-line duty is never driven
    if (panel_output_on && r.scan_row <= row_max) begin
      r_nxt.drive.backplane_drive_outputs = BACKPLANE_FIRST << r.scan_row;
      r_nxt.drive.column_drive_outputs = r.ram_bits[r.scan_row];
    end else begin
      r_nxt.drive = '0;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
      r.index_pointer <= REG_RESET;
      r.panel_setup <= REG_RESET;
      r.panel_control <= REG_RESET;
    end else begin
      r <= r_nxt;
    end
  end

  assign rdata_o = r.read_latch;
  // drive the data pins only while a data-port read strobe is low
  assign rdata_oe_o = ~port.access_pulse & ~r.strobe_prev
                      & port.register_space_select & port.read_not_write
                      & (sel == SEL_DATA);
  assign panel_drive_o = r.drive;
  assign supply_o.module_sleep = r.panel_setup[SETUP_SLEEP_BIT];
  assign supply_o.supply_to_ladder_on = r.panel_control[CTRL_SUPPLY_BIT]
    & ~r.panel_setup[SETUP_SLEEP_BIT];
  assign supply_o.ladder_divider_on = r.panel_control[CTRL_DIVIDER_BIT]
    & ~r.panel_setup[SETUP_SLEEP_BIT];

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence pointer_write_s;
    fall && !port.register_space_select && !port.read_not_write;
  endsequence

  sequence sleep_write_s;
    fall && port.register_space_select && !port.read_not_write
      && sel == SEL_SETUP && port.data[SETUP_SLEEP_BIT];
  endsequence

  ptr_write_a: assert property (
    pointer_write_s |=> r.index_pointer == $past(port.data))
    else $error("pointer not loaded from port");

  sleep_clears_a: assert property (
    sleep_write_s |=> !r.panel_control[CTRL_ON_BIT]
      && !supply_o.supply_to_ladder_on && !supply_o.ladder_divider_on
      && supply_o.module_sleep)
    else $error("sleep did not clear control bits");

  blank_off_a: assert property (
    !panel_output_on |=> panel_drive_o == '0)
    else $error("panel driven while off");

  eighth_rows_a: assert property (
    duty_eighth_select
      |=> panel_drive_o.backplane_drive_outputs[15:8] == '0)
    else $error("hidden row driven in eight-line duty");

  hold_read_a: assert property (
    data_read && readback_hold_mode |=> $stable(r.row_position)
      && $stable(r.column_position))
    else $error("address moved after read in hold mode");

  row_step_a: assert property (
    data_write && !axis_column_first && r.row_position < row_max
      |=> r.row_position == $past(r.row_position) + 4'h1
      && $stable(r.column_position))
    else $error("row step wrong");

  col_step_a: assert property (
    data_write && axis_column_first && r.column_position < COL_MAX
      |=> r.column_position == $past(r.column_position) + 3'h1
      && $stable(r.row_position))
    else $error("column step wrong");

  row_wrap_a: assert property (
    step && !axis_column_first && r.row_position == row_max
      && r.column_position < COL_MAX
      |=> r.row_position == '0
      && r.column_position == $past(r.column_position) + 3'h1)
    else $error("row wrap wrong");

  read_step_a: assert property (
    data_read && !readback_hold_mode && !axis_column_first
      && r.row_position < row_max
      |=> r.row_position == $past(r.row_position) + 4'h1)
    else $error("read did not step address");

  no_select_a: assert property (
    fall && port.register_space_select && sel > SEL_DATA
      |=> $stable(r.panel_setup) && $stable(r.panel_control)
      && $stable(r.row_position) && $stable(r.column_position))
    else $error("unassigned pointer code changed a register");

  oe_data_only_a: assert property (
    rdata_oe_o |-> sel == SEL_DATA && port.register_space_select)
    else $error("read answered from a write-only register");

  one_access_a: assert property (
    fall |=> !fall [*2])
    else $error("strobe gave more than one access");

  reset_zero_a: assert property (
    !$past(nrst_i) |-> r.index_pointer == REG_RESET
      && r.panel_setup == REG_RESET && r.panel_control == REG_RESET)
    else $error("registers not cleared by reset");

  pointer_read_a: assert property (
    fall && !port.register_space_select && port.read_not_write
      |=> $stable(r.index_pointer))
    else $error("pointer changed on a read");

  duty_write_a: assert property (
    fall && port.register_space_select && !port.read_not_write
      && sel == SEL_SETUP
      |=> duty_eighth_select == $past(port.data[SETUP_DUTY_BIT]))
    else $error("duty bit not taken from port");

  sleep_supply_a: assert property (
    supply_o.module_sleep |-> !supply_o.supply_to_ladder_on
      && !supply_o.ladder_divider_on)
    else $error("ladder fed during sleep");

  read_latch_a: assert property (
    data_read && col_ok |=> rdata_o
      == $past(r.ram_bits[r.row_position][r.column_position]))
    else $error("read latch does not hold the bitmap byte");

  read_drive_a: assert property (
    data_read |=> rdata_oe_o)
    else $error("data pins not driven after a read");

  // the filter must keep a seen strobe low long enough to act once
  strobe_filter_a: assert property (
    fall |-> !port.access_pulse ##1 !port.access_pulse)
    else $error("filtered strobe low for under two cycles");

endmodule

/* test/host_port_model.sv */
// host processor model driving the strobed register port
`timescale 1ns/1ns
module host_port_model (
  input wire logic core_clk_i,
  output dot_panel_pkg::host_port_s host_port_o
);
  import dot_panel_pkg::*;
  initial host_port_o = '{1'b0, 1'b0, 1'b1, 8'h00};
  // selects settle before the fall and hold after it, past the sync delay
  task automatic access(input logic rs, input logic rnw, input logic [7:0] d);
    @(posedge core_clk_i);
    #1;
    host_port_o.register_space_select = rs;
    host_port_o.read_not_write = rnw;
    // pins released on reads: show the inverse, never a stale value
    host_port_o.data = rnw ? ~host_port_o.data : d;
    repeat (6) @(posedge core_clk_i);
    #1 host_port_o.access_pulse = 1'b0;
    repeat (7) @(posedge core_clk_i);
    #1 host_port_o.access_pulse = 1'b1;
    repeat (7) @(posedge core_clk_i);
    // callers look at outputs away from the launching edge
    @(negedge core_clk_i);
  endtask
endmodule

/* test/dot_matrix_panel_control_regs_tb.sv */
// self-checking bench for the panel register front end
`timescale 1ns/1ns
module dot_matrix_panel_control_regs_tb;
  import dot_panel_pkg::*;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  host_port_s host_port;
  logic [7:0] rdata;
  logic rdata_oe;
  panel_drive_s drive;
  supply_ctrl_s supply;
  logic [7:0] mem [0:4][0:15] = '{default: 8'h00};
  logic [7:0] exp_q [$];
  logic [31:0] seed = 32'hc3d79f94;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  logic [2:0] col = 3'h0;
  logic [3:0] row = 4'h0;
  logic hold = 1'b0;
  logic axis = 1'b0;
  logic eighth = 1'b0;
  logic oe_q = 1'b0;

  always #5 core_clk_i = ~core_clk_i;

  host_port_model i_host (.core_clk_i(core_clk_i), .host_port_o(host_port));
  dot_matrix_panel_control_regs i_dut (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .host_port_i(host_port),
    .rdata_o(rdata),
    .rdata_oe_o(rdata_oe),
    .panel_drive_o(drive),
    .supply_o(supply)
  );

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // unassigned bits always zero from this host
  task automatic wreg(input logic [2:0] sel, input logic [7:0] v);
    i_host.access(1'b0, 1'b0, {5'h00, sel});
    i_host.access(1'b1, 1'b0, v);
  endtask

  task automatic step();
    logic [3:0] rmax;
    rmax = eighth ? ROW_MAX_EIGHTH : ROW_MAX_FULL;
    if (!axis && row != rmax) begin
      row++;
    end else if (!axis) begin
      row = 4'h0;
      col = (col == COL_MAX) ? 3'h0 : col + 3'h1;
    end else if (col != COL_MAX) begin
      col++;
    end else begin
      col = 3'h0;
      row = (row == rmax) ? 4'h0 : row + 4'h1;
    end
  endtask

  // column kept within 0-4 by every caller
  task automatic setpos(input logic [2:0] c, input logic [3:0] r);
    wreg(SEL_POSITION, {c, 1'b0, r});
    col = c;
    row = r;
    i_host.access(1'b0, 1'b0, {5'h00, SEL_DATA});
  endtask

  task automatic dwrite();
    logic [7:0] d;
    d = rnd();
    mem[col][row] = d;
    i_host.access(1'b1, 1'b0, d);
    step();
  endtask

  task automatic dread();
    exp_q.push_back(mem[col][row]);
    i_host.access(1'b1, 1'b1, 8'h00);
    if (!hold) step();
  endtask

  // each read answer is matched against the oldest note
  always @(negedge core_clk_i) begin
    if (rdata_oe === 1'b1 && oe_q !== 1'b1) begin
      if (exp_q.size() == 0) check(64'(rdata_oe), 64'h0);
      else check(64'(rdata), 64'(exp_q.pop_front()));
    end
    oe_q = rdata_oe;
  end

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    repeat (20) @(posedge core_clk_i);
    #1 nrst_i = 1'b1;
    repeat (8) @(negedge core_clk_i);
    check(64'(supply), 64'h0);
    check(64'(drive), 64'h0);
    // internal supply in use, so the supply bits may be set
    wreg(SEL_CONTROL, 8'h70);
    check(64'(supply), 64'h3);
    setpos(3'h0, 4'h0);
    for (int i = 0; i < 20; i++) dwrite();
    setpos(3'h0, 4'h0);
    for (int i = 0; i < 20; i++) dread();
    for (int r = 0; r < 16; r++) begin
      for (int k = 0; k < 40; k++) begin
        @(negedge core_clk_i);
        if (drive.backplane_drive_outputs === 16'h0001 << r) break;
      end
      check(64'(drive), {8'h00, 16'h0001 << r, mem[4][r], mem[3][r],
        mem[2][r], mem[1][r], mem[0][r]});
    end
    wreg(SEL_CONTROL, 8'h78);
    hold = 1'b1;
    setpos(3'h1, 4'h2);
    dread();
    dread();
    dwrite();
    dread();
    wreg(SEL_CONTROL, 8'h72);
    hold = 1'b0;
    axis = 1'b1;
    setpos(3'h3, 4'h5);
    for (int i = 0; i < 4; i++) dwrite();
    setpos(3'h3, 4'h5);
    for (int i = 0; i < 4; i++) dread();
    i_host.access(1'b0, 1'b1, 8'h00);
    wreg(SEL_CONTROL, 8'h70);
    i_host.access(1'b1, 1'b1, 8'h00);
    axis = 1'b0;
    wreg(SEL_SETUP, 8'h02);
    eighth = 1'b1;
    setpos(3'h0, 4'h7);
    dwrite();
    dwrite();
    setpos(3'h1, 4'h0);
    dread();
    for (int k = 0; k < 40; k++) begin
      @(negedge core_clk_i);
      check(64'(drive.backplane_drive_outputs[15:8]), 64'h0);
    end
    wreg(3'h5, 8'h20);
    check(64'(supply), 64'h3);
    wreg(SEL_FRAME, 8'h05);
    check(64'(supply), 64'h3);
    wreg(SEL_SETUP, 8'h20);
    check(64'(supply), 64'h4);
    check(64'(drive), 64'h0);
    wreg(SEL_SETUP, 8'h00);
    check(64'(supply), 64'h0);
    check(64'(drive), 64'h0);
    check(64'(exp_q.size()), 64'h0);
    stop_test();
  end
endmodule
